// File: hw/apgs_top.sv
`timescale 1ns/1ps
`include "apgs_regs.svh"

module apgs_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Arbitration side
  input wire logic page_ack_in,
  input wire logic abort_in,
  output logic [15:0] page_out,
  output logic page_valid_out,
  output logic [1:0] page_idx_out,
  output logic exchange_done_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  apgs_pkg::apgs_state_t state, next_state;
  logic [4:0] ctrl, next_ctrl;
  logic [15:0] adv, next_adv;
  logic [10:0] seed, next_seed;
  logic [4:0] lat_ctrl, next_lat_ctrl;
  logic [15:0] lat_adv, next_lat_adv;
  logic [10:0] lat_seed, next_lat_seed;
  logic done, next_done;
  logic [1:0] idx, next_idx;
  logic [15:0] next_page;
  logic next_valid;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic [15:0] fmt_word;
  logic wb_req;
  logic wr_ctrl;
  logic busy;
  logic start_req;
  logic done_clr;
  logic last_ack;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------

  // New request, not yet answered
  assign wb_req = wb_cyc_in && wb_stb_in && !ack;
  assign wr_ctrl = wb_req && wb_we_in && (wb_adr_in == `APGS_CTRL_ADDR) && wb_sel_in[0];
  assign busy = (state != apgs_pkg::APGS_IDLE);

  // ----------------------------------------
  // Page formatter
  // ----------------------------------------
  apgs_page_fmt u_fmt (
    .page_idx_in(next_idx),
    .adv_in(next_lat_adv),
    .half_in(next_lat_ctrl[0]),
    .full_in(next_lat_ctrl[1]),
    .mport_in(next_lat_ctrl[2]),
    .role_in(next_lat_ctrl[3]),
    .manual_in(next_lat_ctrl[4]),
    .seed_in(next_lat_seed),
    .page_out(fmt_word)
  );

  // ----------------------------------------
  // Register file next values
  // ----------------------------------------

  // Software writes and reads
  always_comb begin
    next_ctrl = ctrl;
    next_adv = adv;
    next_seed = seed;
    next_ack = wb_req;
    next_rdata = rdata;
    if (wb_req && wb_we_in) begin
      if (wb_adr_in == `APGS_CTRL_ADDR) begin
        if (wb_sel_in[1]) begin
          next_ctrl = wb_dat_in[`APGS_CTRL_MANUAL_BIT:`APGS_CTRL_HALF_BIT];
        end
      end else if (wb_adr_in == `APGS_ADV_ADDR) begin
        if (wb_sel_in[0]) begin
          next_adv[7:0] = wb_dat_in[7:0];
        end
        if (wb_sel_in[1]) begin
          next_adv[15:8] = wb_dat_in[15:8];
        end
      end else if (wb_adr_in == `APGS_SEED_ADDR) begin
        if (wb_sel_in[0]) begin
          next_seed[7:0] = wb_dat_in[7:0];
        end
        if (wb_sel_in[1]) begin
          next_seed[10:8] = wb_dat_in[10:8];
        end
      end
    end else if (wb_req) begin
      next_rdata = 32'h0000_0000;
      if (wb_adr_in == `APGS_CTRL_ADDR) begin
        next_rdata[`APGS_CTRL_MANUAL_BIT:`APGS_CTRL_HALF_BIT] = ctrl;
      end else if (wb_adr_in == `APGS_ADV_ADDR) begin
        next_rdata[15:0] = adv;
      end else if (wb_adr_in == `APGS_SEED_ADDR) begin
        next_rdata[10:0] = seed;
      end else if (wb_adr_in == `APGS_STATUS_ADDR) begin
        next_rdata[`APGS_STAT_BUSY_BIT] = busy;
        next_rdata[`APGS_STAT_DONE_BIT] = done;
        next_rdata[`APGS_STAT_IDX_LSB+1:`APGS_STAT_IDX_LSB] = idx;
      end
    end
  end

  // Register file flops
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl <= `APGS_CTRL_RST;
      adv <= `APGS_ADV_RST;
      seed <= `APGS_SEED_RST;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      adv <= next_adv;
      seed <= next_seed;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Advertisement snapshot
  // ----------------------------------------

  // Start pulse accepted only while no exchange runs
  assign start_req = wr_ctrl && wb_dat_in[`APGS_CTRL_START_BIT] && !busy;

  // Capture control bits, advertisement and seed at start
  always_comb begin
    next_lat_ctrl = lat_ctrl;
    next_lat_adv = lat_adv;
    next_lat_seed = lat_seed;
    if (start_req) begin
      next_lat_ctrl = next_ctrl;
      next_lat_adv = adv;
      next_lat_seed = seed;
    end
  end

  // Snapshot flops; later writes wait for the next start
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lat_ctrl <= `APGS_CTRL_RST;
      lat_adv <= `APGS_ADV_RST;
      lat_seed <= `APGS_SEED_RST;
    end else begin
      lat_ctrl <= next_lat_ctrl;
      lat_adv <= next_lat_adv;
      lat_seed <= next_lat_seed;
    end
  end

  // ----------------------------------------
  // Page sequencer
  // ----------------------------------------

  // Walk the four pages on arbitration acks
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_valid = 1'b0;
    case (state)
      apgs_pkg::APGS_IDLE: begin
        if (start_req) begin
          next_idx = `APGS_PAGE_IDX_BASE;
          next_state = apgs_pkg::APGS_BASE;
          next_valid = 1'b1;
        end
      end
      apgs_pkg::APGS_BASE: begin
        next_valid = 1'b1;
        if (page_ack_in) begin
          next_idx = `APGS_PAGE_IDX_MSG;
          next_state = apgs_pkg::APGS_MSG;
        end
      end
      apgs_pkg::APGS_MSG: begin
        next_valid = 1'b1;
        if (page_ack_in) begin
          next_idx = `APGS_PAGE_IDX_UNF1;
          next_state = apgs_pkg::APGS_UNF1;
        end
      end
      apgs_pkg::APGS_UNF1: begin
        next_valid = 1'b1;
        if (page_ack_in) begin
          next_idx = `APGS_PAGE_IDX_UNF2;
          next_state = apgs_pkg::APGS_UNF2;
        end
      end
      apgs_pkg::APGS_UNF2: begin
        next_valid = 1'b1;
        if (page_ack_in) begin
          // Last required page; no optional pages sent
          next_valid = 1'b0;
          next_state = apgs_pkg::APGS_IDLE;
        end
      end
      default: begin
        next_state = apgs_pkg::APGS_IDLE;
      end
    endcase
    // Abort drops the exchange at once
    if (abort_in && busy) begin
      next_state = apgs_pkg::APGS_IDLE;
      next_valid = 1'b0;
    end
  end

  // Sequencer flops
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= apgs_pkg::APGS_IDLE;
      idx <= `APGS_PAGE_IDX_BASE;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  // ----------------------------------------
  // Page output register
  // ----------------------------------------

  // All zeros whenever no page is offered
  assign next_page = next_valid ? fmt_word : 16'h0000;

  // Page word and valid flops
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      page_out <= 16'h0000;
      page_valid_out <= 1'b0;
    end else begin
      page_out <= next_page;
      page_valid_out <= next_valid;
    end
  end

  // ----------------------------------------
  // Exchange done flag
  // ----------------------------------------

  // Software clear: write one to the status done bit
  assign done_clr = wb_req && wb_we_in && (wb_adr_in == `APGS_STATUS_ADDR) && wb_sel_in[0] &&
    wb_dat_in[`APGS_STAT_DONE_BIT];
  // Last required page accepted
  assign last_ack = (state == apgs_pkg::APGS_UNF2) && page_ack_in;

  // Sticky flag; a set in the same cycle beats the clear
  always_comb begin
    next_done = done;
    if (done_clr) begin
      next_done = 1'b0;
    end
    if (last_ack) begin
      next_done = 1'b1;
    end
  end

  // Done flop
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      done <= 1'b0;
    end else begin
      done <= next_done;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_dat_out = rdata;
  assign wb_ack_out = ack;
  assign page_idx_out = idx;
  assign exchange_done_out = done;

endmodule : apgs_top

// File: hw/apgs_regs.svh
`ifndef APGS_REGS_SVH
`define APGS_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define APGS_CTRL_ADDR 8'h00
`define APGS_ADV_ADDR 8'h04
`define APGS_SEED_ADDR 8'h08
`define APGS_STATUS_ADDR 8'h0C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define APGS_CTRL_START_BIT 0
`define APGS_CTRL_HALF_BIT 8
`define APGS_CTRL_FULL_BIT 9
`define APGS_CTRL_MPORT_BIT 10
`define APGS_CTRL_ROLE_BIT 11
`define APGS_CTRL_MANUAL_BIT 12

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define APGS_STAT_BUSY_BIT 0
`define APGS_STAT_DONE_BIT 1
`define APGS_STAT_IDX_LSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define APGS_CTRL_RST 5'h00
`define APGS_ADV_RST 16'h0001
`define APGS_SEED_RST 11'h000

// ----------------------------------------
// Page layout constants
// ----------------------------------------
`define APGS_NP_BIT 15
`define APGS_MP_BIT 13
`define APGS_ACK2_BIT 12
`define APGS_MSG_CODE 11'h008
`define APGS_PAGE_IDX_BASE 2'h0
`define APGS_PAGE_IDX_MSG 2'h1
`define APGS_PAGE_IDX_UNF1 2'h2
`define APGS_PAGE_IDX_UNF2 2'h3

`endif

// File: hw/apgs_pkg.sv
package apgs_pkg;

  // ----------------------------------------
  // Page sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    APGS_IDLE = 5'h01,
    APGS_BASE = 5'h02,
    APGS_MSG = 5'h04,
    APGS_UNF1 = 5'h08,
    APGS_UNF2 = 5'h10
  } apgs_state_t;

endpackage : apgs_pkg

// File: hw/apgs_page_fmt.sv
`timescale 1ns/1ps
`include "apgs_regs.svh"

module apgs_page_fmt (
  // Page selection
  input wire logic [1:0] page_idx_in,
  // Latched advertisement
  input wire logic [15:0] adv_in,
  input wire logic half_in,
  input wire logic full_in,
  input wire logic mport_in,
  input wire logic role_in,
  input wire logic manual_in,
  input wire logic [10:0] seed_in,
  // Formatted page word
  output logic [15:0] page_out
);

  // Build the page word for the selected page
  always_comb begin
    page_out = 16'h0000;
    if (page_idx_in == `APGS_PAGE_IDX_BASE) begin
      page_out[14:0] = adv_in[14:0];
      page_out[`APGS_NP_BIT] = 1'b1;
    end else if (page_idx_in == `APGS_PAGE_IDX_MSG) begin
      page_out[`APGS_NP_BIT] = 1'b1;
      page_out[`APGS_MP_BIT] = 1'b1;
      page_out[10:0] = `APGS_MSG_CODE;
    end else if (page_idx_in == `APGS_PAGE_IDX_UNF1) begin
      page_out[`APGS_NP_BIT] = 1'b1;
      page_out[10:5] = 6'h00;
      page_out[4] = half_in;
      page_out[3] = full_in;
      page_out[2] = mport_in;
      page_out[1] = role_in;
      page_out[0] = manual_in;
    end else begin
      page_out[10:0] = seed_in;
      page_out[`APGS_NP_BIT] = 1'b0;
    end
    // Ack2 carries nothing on the message and unformatted pages; the base page keeps adv_in[12]
    if (page_idx_in != `APGS_PAGE_IDX_BASE) begin
      page_out[`APGS_ACK2_BIT] = 1'b0;
    end
  end

endmodule : apgs_page_fmt

// File: verification/apgs_partner.sv
`timescale 1ns/1ps
// Arbitration side: acknowledges each offered page after a set delay
module apgs_partner (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Page link
  input wire logic page_valid_in,
  input wire logic [2:0] dly_in,
  output logic page_ack_out
);
  logic [2:0] cnt;
  // One ack per page, in offered order; Ack2 bit never inspected
  always_ff @(posedge clk_in) begin
    if (srst_in || !page_valid_in || page_ack_out) begin
      page_ack_out <= 1'b0;
      cnt <= 3'h0;
    end else if (cnt == dly_in) begin
      page_ack_out <= 1'b1;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule : apgs_partner

// File: verification/apgs_top_chk.sv
`timescale 1ns/1ps
// Page link and bus checks
module apgs_top_chk (
  // Clock, reset, bus
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  // Page link
  input wire logic page_ack_in,
  input wire logic abort_in,
  input wire logic [15:0] page_out,
  input wire logic page_valid_out,
  input wire logic [1:0] page_idx_out,
  input wire logic exchange_done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire acc = page_valid_out && page_ack_in && !abort_in;
  // Page contents
  a_base_msb: assert property (page_valid_out && page_idx_out == 2'h0 |-> page_out[15])
    else $error("base top bit clear");
  a_msg_code: assert property (page_valid_out && page_idx_out == 2'h1 |->
    page_out[10:0] == 11'h008) else $error("bad message code");
  a_unf1_resv: assert property (page_valid_out && page_idx_out == 2'h2 |->
    page_out[10:5] == 6'h00) else $error("reserved bits set");
  a_ack2_zero: assert property (page_valid_out && page_idx_out != 2'h0 |->
    !page_out[12]) else $error("ack2 bit set");
  // Page order and holding
  a_page_order: assert property (acc && page_idx_out != 2'h3 |=>
    page_valid_out && page_idx_out == $past(page_idx_out) + 2'h1) else $error("bad page order");
  a_last_done: assert property (acc && page_idx_out == 2'h3 |=>
    !page_valid_out && exchange_done_out) else $error("no done after last page");
  a_page_hold: assert property (page_valid_out && !page_ack_in && !abort_in |=>
    page_valid_out && $stable(page_out) && $stable(page_idx_out)) else $error("page not held");
  a_bus_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus not answered");
  c_last: cover property (acc && page_idx_out == 2'h3);
  c_abort: cover property (page_valid_out && abort_in);
  c_stall: cover property (page_valid_out && !page_ack_in);
endmodule : apgs_top_chk

bind apgs_top apgs_top_chk i_chk (
  .clk_in(clk_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_ack_out(wb_ack_out), .page_ack_in(page_ack_in), .abort_in(abort_in),
  .page_out(page_out), .page_valid_out(page_valid_out), .page_idx_out(page_idx_out),
  .exchange_done_out(exchange_done_out)
);

// File: verification/apgs_top_tb_top.sv
`timescale 1ns/1ps
`include "apgs_regs.svh"
module apgs_top_tb_top;
  logic clk_in, srst_in, cyc, stb, we, abort, pack, ack, pv, done;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rd_d;
  logic [15:0] pg;
  logic [1:0] pidx;
  logic [2:0] pdly;
  int err_total, n_compared;
  logic [31:0] exp_rd[$];
  logic [15:0] exp_pg[$];
  // Design and far side
  apgs_top i_dut (.clk_in(clk_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rd_d),
    .wb_ack_out(ack), .page_ack_in(pack), .abort_in(abort), .page_out(pg),
    .page_valid_out(pv), .page_idx_out(pidx), .exchange_done_out(done));
  apgs_partner i_far (.clk_in(clk_in), .srst_in(srst_in), .page_valid_in(pv),
    .dly_in(pdly), .page_ack_out(pack));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      err_total++;
      stop_test();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  // One full exchange; registers rewritten mid-way
  task automatic xchg(input logic [4:0] c);
    logic [15:0] av;
    logic [10:0] sd;
    int n;
    av = 16'($urandom);
    sd = 11'($urandom);
    n = 0;
    pdly <= 3'($urandom_range(3));
    wb(1'b1, `APGS_ADV_ADDR, {16'h0, av});
    wb(1'b1, `APGS_SEED_ADDR, {21'h0, sd});
    exp_pg.push_back({1'b1, av[14:0]});
    exp_pg.push_back(16'hA008);
    exp_pg.push_back({11'h400, c[0], c[1], c[2], c[3], c[4]});
    exp_pg.push_back({5'h00, sd});
    wb(1'b1, `APGS_CTRL_ADDR, {19'h0, c, 8'h01});
    wb(1'b1, `APGS_ADV_ADDR, {16'h0, ~av});
    wb(1'b1, `APGS_SEED_ADDR, {21'h0, ~sd});
    wb(1'b1, `APGS_CTRL_ADDR, {19'h0, ~c, 8'h00});
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 300) begin
      err_total++;
      stop_test();
    end
    chk("pages left", 32'h0, exp_pg.size());
    rd(`APGS_STATUS_ADDR, 32'h32);
    rd(`APGS_CTRL_ADDR, {19'h0, ~c, 8'h00});
    wb(1'b1, `APGS_STATUS_ADDR, 32'h2);
    @(posedge clk_in);
    chk("done clear", 32'h0, {31'h0, done});
  endtask : xchg
  // Result watcher
  always @(posedge clk_in) begin
    if (!srst_in && pv === 1'b1 && pack === 1'b1) chk("page", exp_pg.size() > 0 ? {16'h0, exp_pg.pop_front()} : 32'hDEADBEEF, {16'h0, pg});
    if (ack === 1'b1 && we === 1'b0) chk("read", exp_rd.size() > 0 ? exp_rd.pop_front() : 32'hDEADBEEF, rd_d);
  end
  // Main sequence
  initial begin
    {cyc, stb, we, abort, adr, wd, err_total, n_compared} = '0;
    sel = 4'hF;
    pdly = 3'h0;
    srst_in = 1'b1;
    void'($urandom(32'hC977));
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(`APGS_CTRL_ADDR, 32'h0);
    rd(`APGS_ADV_ADDR, 32'h1);
    rd(`APGS_SEED_ADDR, 32'h0);
    rd(`APGS_STATUS_ADDR, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFF);
    rd(8'h10, 32'h0);
    rd(`APGS_ADV_ADDR, 32'h1);
    pdly <= 3'h7;
    wb(1'b1, `APGS_CTRL_ADDR, 32'h1);
    @(posedge clk_in);
    abort <= 1'b1;
    @(posedge clk_in);
    abort <= 1'b0;
    @(posedge clk_in);
    chk("abort valid", 32'h0, {31'h0, pv});
    chk("abort done", 32'h0, {31'h0, done});
    for (int i = 0; i < 32; i++) xchg(i[4:0]);
    stop_test();
  end
endmodule : apgs_top_tb_top
